// File: design/mmcb_pkg.sv
// Package: register map, field layout and types of the second mode register
package mmcb_pkg;
   // Register indices on the A4-A1 address lines
   localparam logic [3:0] MMCB_ADDR_MODE_A   = 4'h9;
   localparam logic [3:0] MMCB_ADDR_MODE_B   = 4'hA;
   // Field positions within the second mode control register, plus the clamp bit of the first
   localparam int         MMCB_BIT_RATE_MSB  = 7;
   localparam int         MMCB_BIT_PWR_DOWN  = 6;
   localparam int         MMCB_BIT_TONE_DET  = 5;
   localparam int         MMCB_BIT_CPM       = 4;
   localparam int         MMCB_BIT_LOOPBACK  = 3;
   localparam int         MMCB_BIT_CLAMP     = 0;
   // Values after reset, and the byte read at an unmapped index
   localparam logic [7:0] MMCB_RST_MODE_B    = 8'h00;
   localparam logic       MMCB_RST_CLAMP     = 1'b0;
   localparam logic [7:0] MMCB_RD_UNMAPPED   = 8'h00;
   // Transmit level figures in dB below 1 mW
   localparam logic [4:0] MMCB_LVL_MODEM_TOP = 5'h03;
   localparam logic [4:0] MMCB_LVL_FAX_TOP   = 5'h05;
   localparam logic [4:0] MMCB_LVL_STEP      = 5'h02;

   // Receive path routing choices
   typedef enum logic [1:0] {
      MMCB_RX_FILTER   = 2'b00,
      MMCB_RX_LOOPBACK = 2'b01,
      MMCB_RX_HIGHBAND = 2'b10,
      MMCB_RX_LOWBAND  = 2'b11
   } mmcb_rx_path_t;

   // Layout of the second mode control register
   typedef struct packed {
      logic       rate_select_msb;
      logic       power_down_ctl;
      logic       answer_tone_detect_en;
      logic       call_progress_monitor;
      logic       analog_loopback;
      logic [2:0] tx_level_sel;
   } mmcb_mode_t;

   // One decoded host access
   typedef struct packed {
      logic       wr_stb;
      logic       rd_act;
      logic [3:0] addr;
      logic [7:0] wdata;
   } mmcb_acc_t;
endpackage

// File: design/mmcb_busif.sv
// Multiplexed host bus front end: address latch and strobe decode
`timescale 1ns/1ps
module mmcb_busif
   import mmcb_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       srst_in,
   input  wire logic       ale_in,
   input  wire logic [3:0] addr_in,
   input  wire logic       cs_n_in,
   input  wire logic       rd_n_in,
   input  wire logic       wr_n_in,
   input  wire logic [7:0] data_in,
   output mmcb_acc_t       acc_out
);
   logic [3:0] addr_r;
   logic [3:0] addr_nxt;
   logic       wr_n_d_r;
   logic       wr_n_d_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Address is latched while ALE is high; write fires once per strobe
   always_comb begin
      addr_nxt   = ale_in ? addr_in : addr_r;
      wr_n_d_nxt = wr_n_in;
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         addr_r   <= 4'h0;
         wr_n_d_r <= 1'b1;
      end else begin
         addr_r   <= addr_nxt;
         wr_n_d_r <= wr_n_d_nxt;
      end
   end

   // Falling edge of the write strobe, so a long strobe writes only once
   always_comb begin
      acc_out.wr_stb = !cs_n_in && !wr_n_in && wr_n_d_r;
      acc_out.rd_act = !cs_n_in && !rd_n_in;
      acc_out.addr   = addr_r;
      acc_out.wdata  = data_in;
   end
endmodule // mmcb_busif

// File: design/mmcb_top.sv
// Second mode control register bank with receive clamp and mode decode
`timescale 1ns/1ps
module mmcb_top
   import mmcb_pkg::*;
#(
   parameter int DATA_W = 8
)
(
   input  wire logic       sys_clk_in,
   input  wire logic       srst_in,
   input  wire logic       ale_in,
   input  wire logic [3:0] addr_in,
   input  wire logic       cs_n_in,
   input  wire logic       rd_n_in,
   input  wire logic       wr_n_in,
   input  wire logic [7:0] data_in,
   output logic      [7:0] data_out,
   output logic            data_oe_out,
   input  wire logic [2:0] rate_select_low_in,
   input  wire logic       demod_rxd_in,
   output logic            rxd_out,
   output logic      [3:0] rate_code_out,
   output logic            fax_mode_out,
   output logic            power_down_out,
   output logic            tone_detect_en_out,
   output mmcb_rx_path_t   rx_path_out,
   output logic      [4:0] tx_level_db_out
);
   // Only a byte-wide host bus is served
   if (DATA_W != 8) begin : g_chk
      $error("mmcb_top: DATA_W must be 8");
   end

   mmcb_acc_t     acc;
   mmcb_mode_t    mode_r;
   mmcb_mode_t    mode_nxt;
   logic          clamp_r;
   logic          clamp_nxt;
   logic [7:0]    rdata_r;
   logic [7:0]    rdata_nxt;
   logic          oe_r;
   logic          oe_nxt;
   logic          rxd_r;
   logic          rxd_nxt;
   logic [3:0]    rate_r;
   logic [3:0]    rate_nxt;
   logic          fax_r;
   logic          fax_nxt;
   logic          pd_r;
   logic          pd_nxt;
   logic          tdet_r;
   logic          tdet_nxt;
   mmcb_rx_path_t path_r;
   mmcb_rx_path_t path_nxt;
   logic [4:0]    lvl_r;
   logic [4:0]    lvl_nxt;

   // Attenuation in dB for a level code; fax tops out 2 dB lower
   function automatic logic [4:0] mmcb_level(input logic       fax,
                                             input logic [2:0] code);
      logic [4:0] step_db;
      step_db = 5'(code) * MMCB_LVL_STEP;
      if (fax && code == 3'h0) begin
         mmcb_level = MMCB_LVL_FAX_TOP;
      end else begin
         mmcb_level = MMCB_LVL_MODEM_TOP + step_db;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Host bus front end
   mmcb_busif u_busif (
      .sys_clk_in (sys_clk_in),
      .srst_in    (srst_in),
      .ale_in     (ale_in),
      .addr_in    (addr_in),
      .cs_n_in    (cs_n_in),
      .rd_n_in    (rd_n_in),
      .wr_n_in    (wr_n_in),
      .data_in    (data_in),
      .acc_out    (acc)
   );

   ////////////////////////////////////////////////////////////////////////
   // Register writes; other bits of the preceding register are not held
   always_comb begin
      mode_nxt  = mode_r;
      clamp_nxt = clamp_r;
      if (acc.wr_stb && acc.addr == MMCB_ADDR_MODE_B) begin
         mode_nxt = mmcb_mode_t'(acc.wdata);
      end
      if (acc.wr_stb && acc.addr == MMCB_ADDR_MODE_A) begin
         clamp_nxt = acc.wdata[MMCB_BIT_CLAMP];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         mode_r  <= mmcb_mode_t'(MMCB_RST_MODE_B);
         clamp_r <= MMCB_RST_CLAMP;
      end else begin
         mode_r  <= mode_nxt;
         clamp_r <= clamp_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path, one cycle behind the strobe; unmapped reads give zero
   always_comb begin
      oe_nxt    = acc.rd_act;
      rdata_nxt = MMCB_RD_UNMAPPED;
      if (acc.addr == MMCB_ADDR_MODE_B) begin
         rdata_nxt = 8'(mode_r);
      end else if (acc.addr == MMCB_ADDR_MODE_A) begin
         rdata_nxt[MMCB_BIT_CLAMP] = clamp_r;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         rdata_r <= 8'h00;
         oe_r    <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         oe_r    <= oe_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode decode; host must itself pick high band when detecting tones
   always_comb begin
      rxd_nxt  = clamp_r ? 1'b1 : demod_rxd_in;
      rate_nxt = {mode_r.rate_select_msb, rate_select_low_in};
      fax_nxt  = mode_r.rate_select_msb | rate_select_low_in[2];
      pd_nxt   = mode_r.power_down_ctl;
      tdet_nxt = mode_r.answer_tone_detect_en;
      case ({mode_r.call_progress_monitor, mode_r.analog_loopback})
         2'b11:   path_nxt = MMCB_RX_HIGHBAND;
         2'b10:   path_nxt = MMCB_RX_LOWBAND;
         2'b01:   path_nxt = MMCB_RX_LOOPBACK;
         default: path_nxt = MMCB_RX_FILTER;
      endcase
      lvl_nxt  = mmcb_level(fax_nxt, mode_r.tx_level_sel);
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         rxd_r  <= 1'b1;
         rate_r <= 4'h0;
         fax_r  <= 1'b0;
         pd_r   <= 1'b0;
         tdet_r <= 1'b0;
         path_r <= MMCB_RX_FILTER;
         lvl_r  <= MMCB_LVL_MODEM_TOP;
      end else begin
         rxd_r  <= rxd_nxt;
         rate_r <= rate_nxt;
         fax_r  <= fax_nxt;
         pd_r   <= pd_nxt;
         tdet_r <= tdet_nxt;
         path_r <= path_nxt;
         lvl_r  <= lvl_nxt;
      end
   end

   // All outputs straight from flip-flops
   assign data_out           = rdata_r;
   assign data_oe_out        = oe_r;
   assign rxd_out            = rxd_r;
   assign rate_code_out      = rate_r;
   assign fax_mode_out       = fax_r;
   assign power_down_out     = pd_r;
   assign tone_detect_en_out = tdet_r;
   assign rx_path_out        = path_r;
   assign tx_level_db_out    = lvl_r;

   ////////////////////////////////////////////////////////////////////////
   // Checks on the outputs against their register causes
   sequence s_write_b;
      acc.wr_stb && acc.addr == MMCB_ADDR_MODE_B;
   endsequence

   sequence s_read_b;
      acc.rd_act && acc.addr == MMCB_ADDR_MODE_B;
   endsequence

   property p_clamp;
      @(posedge sys_clk_in) disable iff (srst_in)
      clamp_r |=> rxd_out;
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("receive output not clamped high");

   property p_write_read;
      @(posedge sys_clk_in) disable iff (srst_in)
      s_write_b ##1 !acc.wr_stb [*5] ##1 s_read_b |=>
         data_oe_out && data_out == $past(acc.wdata, 7);
   endproperty
   a_write_read: assert property (p_write_read)
      else $error("readback differs from written byte");

   property p_rate_msb;
      @(posedge sys_clk_in) disable iff (srst_in)
      s_write_b |=> ##1 rate_code_out[3] == $past(acc.wdata[7], 2);
   endproperty
   a_rate_msb: assert property (p_rate_msb)
      else $error("rate msb not taken from bit 7");

   property p_power_down;
      @(posedge sys_clk_in) disable iff (srst_in)
      s_write_b |=> ##1 power_down_out == $past(acc.wdata[6], 2);
   endproperty
   a_power_down: assert property (p_power_down)
      else $error("power down does not follow bit 6");

   property p_tone_det;
      @(posedge sys_clk_in) disable iff (srst_in)
      $rose(mode_r.answer_tone_detect_en) |=> $rose(tone_detect_en_out);
   endproperty
   a_tone_det: assert property (p_tone_det)
      else $error("tone detector enable late");

   property p_path_cpm;
      @(posedge sys_clk_in) disable iff (srst_in)
      mode_r.call_progress_monitor |=>
         rx_path_out == ($past(mode_r.analog_loopback) ?
                         MMCB_RX_HIGHBAND : MMCB_RX_LOWBAND);
   endproperty
   a_path_cpm: assert property (p_path_cpm)
      else $error("call progress routing wrong");

   property p_loopback;
      @(posedge sys_clk_in) disable iff (srst_in)
      mode_r.analog_loopback && !mode_r.call_progress_monitor |=>
         rx_path_out == MMCB_RX_LOOPBACK;
   endproperty
   a_loopback: assert property (p_loopback)
      else $error("analog loopback not routed");

   property p_modem_level;
      @(posedge sys_clk_in) disable iff (srst_in)
      !fax_nxt |=> tx_level_db_out ==
         5'h03 + 5'h02 * 5'($past(mode_r.tx_level_sel));
   endproperty
   a_modem_level: assert property (p_modem_level)
      else $error("modem transmit level wrong");

   property p_fax_level;
      @(posedge sys_clk_in) disable iff (srst_in)
      fax_nxt && mode_r.tx_level_sel == 3'h0 |=>
         fax_mode_out && tx_level_db_out == 5'h05;
   endproperty
   a_fax_level: assert property (p_fax_level)
      else $error("fax top transmit level wrong");

   property p_unmapped;
      @(posedge sys_clk_in) disable iff (srst_in)
      acc.rd_act && acc.addr != MMCB_ADDR_MODE_A &&
      acc.addr != MMCB_ADDR_MODE_B |=> data_oe_out && data_out == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
endmodule // mmcb_top

// File: sim/mmcb_host_model.sv
// Host controller model driving the multiplexed register bus
`timescale 1ns/1ps
module mmcb_host_model
   import mmcb_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic [7:0] rdata_in,
   input  wire logic       rd_oe_in,
   output logic            ale_out,
   output logic      [3:0] addr_out,
   output logic            cs_n_out,
   output logic            rd_n_out,
   output logic            wr_n_out,
   output logic      [7:0] wdata_out
);
   // Idle bus: strobes high, no chip select
   initial begin
      ale_out   = 1'b0;
      addr_out  = 4'h0;
      cs_n_out  = 1'b1;
      rd_n_out  = 1'b1;
      wr_n_out  = 1'b1;
      wdata_out = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////
   // Address phase; the latch settles before the strobe cycle
   task automatic addr_phase(input logic [3:0] a);
      @(negedge clk_in);
      ale_out  = 1'b1;
      addr_out = a;
      @(negedge clk_in);
      ale_out  = 1'b0;
      addr_out = ~a;
   endtask
   // Write; the strobe idles a full cycle so the next write is seen
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      addr_phase(a);
      cs_n_out  = 1'b0;
      wr_n_out  = 1'b0;
      wdata_out = d;
      @(negedge clk_in);
      cs_n_out  = 1'b1;
      wr_n_out  = 1'b1;
      wdata_out = ~d; // Released bus must not show a stale byte
      @(negedge clk_in);
   endtask
   // Read; strobe held until the registered answer has landed
   task automatic rd(input logic [3:0] a, output logic [7:0] d,
                     output logic oe);
      addr_phase(a);
      cs_n_out = 1'b0;
      rd_n_out = 1'b0;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      d        = rdata_in;
      oe       = rd_oe_in;
      cs_n_out = 1'b1;
      rd_n_out = 1'b1;
      @(negedge clk_in);
   endtask
endmodule // mmcb_host_model

// File: sim/mmcb_top_tb.sv
// Self-checking testbench of the second mode control register bank
`timescale 1ns/1ps
module mmcb_top_tb;
   import mmcb_pkg::*;
   logic          clk, srst_in, ale, cs_n, rd_n, wr_n, d_oe;
   logic          rxd, fax, pd, tone, demod, rdv_oe;
   logic    [3:0] addr, rate_code;
   logic    [2:0] rate_low;
   logic    [7:0] wdata, d_out, rdv, v;
   logic    [4:0] lvl, elvl;
   mmcb_rx_path_t rx_path;
   int            bad_count;
   int            cmp_count;
   logic    [7:0] mv [5] = '{8'h60, 8'h00, 8'h08, 8'h10, 8'h38};
   logic    [3:0] me [5] = '{4'hC, 4'h0, 4'h1, 4'h3, 4'h6};

   mmcb_top dut (.sys_clk_in(clk), .srst_in(srst_in), .ale_in(ale),
      .addr_in(addr), .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
      .data_in(wdata), .data_out(d_out), .data_oe_out(d_oe),
      .rate_select_low_in(rate_low), .demod_rxd_in(demod),
      .rxd_out(rxd), .rate_code_out(rate_code), .fax_mode_out(fax),
      .power_down_out(pd), .tone_detect_en_out(tone),
      .rx_path_out(rx_path), .tx_level_db_out(lvl));
   mmcb_host_model host (.clk_in(clk), .rdata_in(d_out),
      .rd_oe_in(d_oe), .ale_out(ale), .addr_out(addr), .cs_n_out(cs_n),
      .rd_n_out(rd_n), .wr_n_out(wr_n), .wdata_out(wdata));

   // 200 MHz clock
   always #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Verdict and end of run
   task automatic end_sim;
      $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Decoded outputs trail the write by two cycles
   task automatic settle;
      repeat (2) @(negedge clk);
   endtask
   // Watchdog: the sequence needs well under a thousand cycles
   initial begin
      #100000;
      bad_count++;
      end_sim();
   end
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      clk = 1'b0;
      srst_in = 1'b1;
      rate_low = 3'h1;
      demod = 1'b0;
      bad_count = 0;
      cmp_count = 0;
      repeat (6) @(negedge clk);
      chk({7'h00, rxd}, 8'h01);
      chk({7'h00, d_oe}, 8'h00);
      chk({3'h0, lvl}, 8'h03);
      chk({4'h0, pd, tone, rx_path}, 8'h00);
      srst_in = 1'b0;
      host.rd(MMCB_ADDR_MODE_B, rdv, rdv_oe);
      chk(rdv, MMCB_RST_MODE_B);
      // Level codes in modem mode, fax by rate bit 2 and fax by bit 7
      for (int m = 0; m < 3; m++) begin
         for (int c = 0; c < 8; c++) begin
            rate_low = (m == 1) ? 3'h4 : 3'h1;
            v = {(m == 2), 4'h0, 3'(c)};
            host.wr(MMCB_ADDR_MODE_B, v);
            settle();
            host.rd(MMCB_ADDR_MODE_B, rdv, rdv_oe);
            chk(rdv, v);
            chk({7'h00, rdv_oe}, 8'h01);
            elvl = MMCB_LVL_MODEM_TOP + MMCB_LVL_STEP * 5'(c);
            if (m != 0 && c == 0)
               elvl = MMCB_LVL_FAX_TOP;
            chk({3'h0, lvl}, {3'h0, elvl});
            chk({7'h00, fax}, {7'h00, m != 0});
            chk({4'h0, rate_code}, {4'h0, v[7], rate_low});
         end
      end
      // Power, detector and receive routing; 0x38 is the tone setup
      for (int i = 0; i < 5; i++) begin
         host.wr(MMCB_ADDR_MODE_B, mv[i]);
         settle();
         chk({4'h0, pd, tone, rx_path}, {4'h0, me[i]});
      end
      // Clamp holds the receive output high against low data
      host.wr(MMCB_ADDR_MODE_A, 8'h01);
      settle();
      chk({7'h00, rxd}, 8'h01);
      host.rd(MMCB_ADDR_MODE_A, rdv, rdv_oe);
      chk(rdv, 8'h01);
      host.wr(MMCB_ADDR_MODE_A, 8'hFE);
      settle();
      chk({7'h00, rxd}, 8'h00);
      demod = 1'b1;
      settle();
      chk({7'h00, rxd}, 8'h01);
      // Only index 1010 reaches the register
      host.wr(MMCB_ADDR_MODE_B, 8'h5A);
      host.wr(4'hB, 8'hFF);
      host.wr(4'h2, 8'hA5);
      host.rd(MMCB_ADDR_MODE_B, rdv, rdv_oe);
      chk(rdv, 8'h5A);
      host.rd(4'hB, rdv, rdv_oe);
      chk(rdv, MMCB_RD_UNMAPPED);
      chk({7'h00, rdv_oe}, 8'h01);
      end_sim();
   end
endmodule // mmcb_top_tb
